/* File: src/mau_pkg.sv */
// mau_pkg: widths and reset values shared by the multiply-accumulate unit.
// assumes: included into compile before any mau module.
package mau_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int OP_W = 18;
  localparam int PROD_W = 2 * OP_W;
  localparam int ACC_W = 52;
  localparam int OUT_W = ACC_W + 1;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [OP_W-1:0] OP_RST = 18'h0;
  localparam logic [PROD_W-1:0] PROD_RST = 36'h0;
  localparam logic [ACC_W-1:0] ACC_RST = 52'h0;
  localparam logic [OUT_W-1:0] OUT_RST = 53'h0;
  localparam logic [1:0] CNT_EMPTY = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;
endpackage : mau_pkg

/* File: src/mau_buf.sv */
// mau_buf: two-entry buffer with valid/ready on both sides.
// assumes: single clock, outputs all registered, head entry is the output.
`timescale 1ns/1ns
`default_nettype none
module mau_buf
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [mau_pkg::OUT_W-1:0] in_data,
  output var logic out_valid,
  input wire logic out_ready,
  output var logic [mau_pkg::OUT_W-1:0] out_data
);
  logic [1:0] cnt_q, cnt_d;
  logic [mau_pkg::OUT_W-1:0] head_q, head_d, tail_q, tail_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid && rdy_q;
    pop = out_ready && (cnt_q != mau_pkg::CNT_EMPTY);
    head_d = head_q;
    tail_d = tail_q;
    cnt_d = cnt_q;
    if (pop)
    begin
      head_d = tail_q;
    end
    if (push)
    begin
      // lands in head when head is free after this cycle's pop
      if ((cnt_q == mau_pkg::CNT_EMPTY) || ((cnt_q == mau_pkg::CNT_ONE) && pop))
      begin
        head_d = in_data;
      end
      else
      begin
        tail_d = in_data;
      end
    end
    if (push && !pop)
    begin
      cnt_d = cnt_q + 2'h1;
    end
    else if (pop && !push)
    begin
      cnt_d = cnt_q - 2'h1;
    end
    // ready registered: honest not-full for the next cycle
    rdy_d = (cnt_d != mau_pkg::CNT_FULL);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= mau_pkg::CNT_EMPTY;
      head_q <= mau_pkg::OUT_RST;
      tail_q <= mau_pkg::OUT_RST;
      rdy_q <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      head_q <= head_d;
      tail_q <= tail_d;
      rdy_q <= rdy_d;
      out_valid <= (cnt_d != mau_pkg::CNT_EMPTY);
    end
  end

  assign in_ready = rdy_q;
  assign out_data = head_q;
endmodule : mau_buf
`default_nettype wire

/* File: src/mau_top.sv */
// mau_top: multiply-accumulate unit with optional input and product stages.
// assumes: operands, controls and configuration come from logic on clk;
// stage enables are changed only while the pipe is empty.
//
// Overview of operation
// RULE1: new total is old total plus A times B
// RULE2: current total is shown on result output
// RULE3: input and product stages optional, else combinational
// RULE4: output register is always in the path
// RULE5: output register total feeds next addition
// RULE6: load input restarts total from load value
// RULE7: overflow flag comes from a register
// RULE8: overflow on signed total not fitting width
`timescale 1ns/1ns
`default_nettype none
module mau_top
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_reg_en,
  input wire logic pipe_reg_en,
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [mau_pkg::OP_W-1:0] op_a,
  input wire logic [mau_pkg::OP_W-1:0] op_b,
  input wire logic load,
  input wire logic [mau_pkg::ACC_W-1:0] load_val,
  output var logic [mau_pkg::ACC_W-1:0] result,
  output var logic overflow,
  output var logic out_valid,
  input wire logic out_ready,
  output var logic [mau_pkg::OUT_W-1:0] out_data
);
  // ----------------------------------------
  // stage 1: optional operand registers
  // ----------------------------------------
  logic adv;
  logic v1_q, v1_d, ld1_q, ld1_d;
  logic [mau_pkg::OP_W-1:0] a1_q, a1_d, b1_q, b1_d;
  logic [mau_pkg::ACC_W-1:0] lv1_q, lv1_d;
  logic v_s1, ld_s1;
  logic [mau_pkg::OP_W-1:0] a_s1, b_s1;
  logic [mau_pkg::ACC_W-1:0] lv_s1;
  logic signed [mau_pkg::PROD_W-1:0] prod_s1;

  // the whole pipe stalls on a full buffer, so no word in flight is lost
  always_comb
  begin
    v1_d = v1_q;
    ld1_d = ld1_q;
    a1_d = a1_q;
    b1_d = b1_q;
    lv1_d = lv1_q;
    if (adv)
    begin
      v1_d = in_valid;
      ld1_d = load;
      a1_d = op_a;
      b1_d = op_b;
      lv1_d = load_val;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      v1_q <= 1'b0;
      ld1_q <= 1'b0;
      a1_q <= mau_pkg::OP_RST;
      b1_q <= mau_pkg::OP_RST;
      lv1_q <= mau_pkg::ACC_RST;
    end
    else
    begin
      v1_q <= v1_d;
      ld1_q <= ld1_d;
      a1_q <= a1_d;
      b1_q <= b1_d;
      lv1_q <= lv1_d;
    end
  end

  always_comb
  begin
    // a disabled stage passes its input straight on
    v_s1 = in_reg_en ? v1_q : in_valid; // RULE3
    ld_s1 = in_reg_en ? ld1_q : load;
    a_s1 = in_reg_en ? a1_q : op_a;
    b_s1 = in_reg_en ? b1_q : op_b;
    lv_s1 = in_reg_en ? lv1_q : load_val;
    prod_s1 = $signed(a_s1) * $signed(b_s1); // RULE1
  end

  // ----------------------------------------
  // stage 2: optional product register
  // ----------------------------------------
  logic v2_q, v2_d, ld2_q, ld2_d;
  logic [mau_pkg::PROD_W-1:0] p2_q, p2_d;
  logic [mau_pkg::ACC_W-1:0] lv2_q, lv2_d;
  logic v_s2, ld_s2;
  logic [mau_pkg::PROD_W-1:0] p_s2;
  logic [mau_pkg::ACC_W-1:0] lv_s2;

  always_comb
  begin
    v2_d = v2_q;
    ld2_d = ld2_q;
    p2_d = p2_q;
    lv2_d = lv2_q;
    if (adv)
    begin
      v2_d = v_s1;
      ld2_d = ld_s1;
      p2_d = prod_s1;
      lv2_d = lv_s1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      v2_q <= 1'b0;
      ld2_q <= 1'b0;
      p2_q <= mau_pkg::PROD_RST;
      lv2_q <= mau_pkg::ACC_RST;
    end
    else
    begin
      v2_q <= v2_d;
      ld2_q <= ld2_d;
      p2_q <= p2_d;
      lv2_q <= lv2_d;
    end
  end

  always_comb
  begin
    v_s2 = pipe_reg_en ? v2_q : v_s1; // RULE3
    ld_s2 = pipe_reg_en ? ld2_q : ld_s1;
    p_s2 = pipe_reg_en ? p2_q : prod_s1;
    lv_s2 = pipe_reg_en ? lv2_q : lv_s1;
  end

  // ----------------------------------------
  // accumulator: output register, never bypassed
  // ----------------------------------------
  logic fire;
  logic [mau_pkg::ACC_W-1:0] acc_q, acc_d, addend, prod_ext, sum;
  logic ovf_q, ovf_d, ovf_now;
  logic buf_ready;

  always_comb
  begin
    adv = buf_ready;
    fire = v_s2 && adv;
    prod_ext = mau_pkg::ACC_W'($signed(p_s2));
    // load starts a new sequence from the load value, else feed back the total
    addend = ld_s2 ? lv_s2 : acc_q; // RULE5 RULE6
    sum = addend + prod_ext; // RULE1
    // signed overflow: like-signed addends give an unlike-signed sum
    ovf_now = (addend[mau_pkg::ACC_W-1] == prod_ext[mau_pkg::ACC_W-1]) &&
              (sum[mau_pkg::ACC_W-1] != addend[mau_pkg::ACC_W-1]); // RULE8
    acc_d = fire ? sum : acc_q; // RULE4
    ovf_d = fire ? ovf_now : ovf_q; // RULE7
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_q <= mau_pkg::ACC_RST;
      ovf_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      ovf_q <= ovf_d;
    end
  end

  assign result = acc_q; // RULE2
  assign overflow = ovf_q; // RULE7

  // ----------------------------------------
  // result stream; buffer entry is written from the registered total
  // ----------------------------------------
  logic push_q, push_d;

  always_comb
  begin
    // a push is pending until the buffer, which froze the pipe, takes it
    push_d = fire || (push_q && !buf_ready);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      push_q <= 1'b0;
    end
    else
    begin
      push_q <= push_d;
    end
  end

  mau_buf u_buf
  (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_q),
    .in_ready(buf_ready),
    .in_data({ovf_q, acc_q}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  assign in_ready = buf_ready;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence acc_step_s;
    fire && !ld_s2;
  endsequence

  sequence load_step_s;
    fire && ld_s2;
  endsequence

  acc_adds_a: assert property (acc_step_s |=> acc_q == $past(acc_q) + $past(prod_ext)) // RULE1
    else $error("total did not add the product");
  result_tracks_a: assert property (fire |=> result == $past(sum)) // RULE2
    else $error("result does not show the new total");
  bypass_path_a: assert property (!in_reg_en && !pipe_reg_en && in_valid && in_ready && !load
                                   |=> result == $past(result) + $past(mau_pkg::ACC_W'($signed(op_a))) *
                                       $past(mau_pkg::ACC_W'($signed(op_b)))) // RULE3
    else $error("bypassed stages did not act in the same cycle");
  in_stage_lat_a: assert property (in_reg_en && !pipe_reg_en && in_valid && in_ready
                                   ##1 (in_reg_en && !pipe_reg_en && in_ready) |=> $changed(push_q) || push_q) // RULE3
    else $error("input stage latency wrong");
  hold_total_a: assert property (!fire |=> $stable(result)) // RULE4
    else $error("total moved without an accumulate");
  load_restart_a: assert property (load_step_s |=> acc_q == $past(lv_s2) + $past(prod_ext)) // RULE6
    else $error("load did not restart the total");
  ovf_aligned_a: assert property (fire |=> overflow == $past(ovf_now)) // RULE7
    else $error("overflow not aligned with the total");
  ovf_hold_a: assert property (!fire |=> $stable(overflow)) // RULE7
    else $error("overflow moved without an accumulate");
  ovf_sign_a: assert property (fire && (addend[mau_pkg::ACC_W-1] == prod_ext[mau_pkg::ACC_W-1])
                               && (sum[mau_pkg::ACC_W-1] != prod_ext[mau_pkg::ACC_W-1]) |=> overflow) // RULE8
    else $error("signed overflow not flagged");
  // an older push still pending would land first, so only an idle buffer is checked
  stream_out_a: assert property (fire && !out_valid && !push_q
                                 |=> ##1 out_valid && out_data == {$past(overflow), $past(result)}) // RULE2
    else $error("total not streamed out");
endmodule : mau_top
`default_nettype wire

/* File: verification/mau_sink.sv */
// mau_sink: fabric sink for the result stream.
// assumes: bench clock; hold and slow come from the bench.
`timescale 1ns/1ns
`default_nettype none
module mau_sink
(
  input wire logic clk,
  input wire logic hold,
  input wire logic slow,
  output var logic out_ready
);
  // ----
  // ready
  // ----
  initial out_ready = 1'h0;
  // slow mode stalls most cycles so the buffer really fills
  always @(posedge clk)
    out_ready <= !hold && (!slow || $urandom_range(3) == 0);
endmodule : mau_sink
`default_nettype wire

/* File: verification/test_multiply_accumulate_unit.sv */
// test_multiply_accumulate_unit: self-checking bench with a queue model.
// assumes: mau_pkg compiled first; mau_sink drives out_ready.
`timescale 1ns/1ns
`default_nettype none
module test_multiply_accumulate_unit;
  logic clk = 1'h0, arst_n = 1'h0, in_reg_en = 1'h0, pipe_reg_en = 1'h0;
  logic in_valid = 1'h0, load = 1'h0, hold = 1'h0, slow = 1'h0;
  logic [mau_pkg::OP_W-1:0] op_a = 18'h0, op_b = 18'h0;
  logic [mau_pkg::ACC_W-1:0] load_val = 52'h0, result;
  logic in_ready, overflow, out_valid, out_ready, ov;
  logic [mau_pkg::OUT_W-1:0] out_data;
  logic signed [mau_pkg::ACC_W-1:0] t;
  logic [mau_pkg::OUT_W-1:0] expq[$];
  longint acc = 0, p, a;
  int bad_count = 0, check_count = 0, k, c;

  mau_top i_mau_top (.clk, .arst_n, .in_reg_en, .pipe_reg_en, .in_valid, .in_ready, .op_a, .op_b,
    .load, .load_val, .result, .overflow, .out_valid, .out_ready, .out_data);
  mau_sink i_mau_sink (.clk, .hold, .slow, .out_ready);

  initial forever #50 clk = ~clk;

  // ----
  // helpers
  // ----
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task give_up;
    bad_count++;
    test_done;
  endtask : give_up

  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // called just after a rising edge; returns at the edge that takes the word
  task send(input logic [17:0] sa, input logic [17:0] sb, input logic ld, input logic [51:0] lv);
    int n;
    in_valid <= 1'h1;
    op_a <= sa;
    op_b <= sb;
    load <= ld;
    load_val <= lv;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!in_ready && n < 99);
    if (n >= 99)
      give_up;
    @(posedge clk);
  endtask : send

  // ----
  // model
  // ----
  always @(posedge clk)
  begin
    if (arst_n && in_valid && in_ready)
    begin
      p = longint'($signed(op_a)) * longint'($signed(op_b));
      a = load ? longint'($signed(load_val)) : acc;
      t = a + p;
      ov = ((a < 0) == (p < 0)) && ((t < 0) != (a < 0));
      acc = t;
      expq.push_back({ov, t});
    end
    if (arst_n && out_valid && out_ready)
    begin
      // a word with nothing taken behind it is a mismatch of its own
      check(expq.size() != 0, 1'h1);
      if (expq.size() != 0)
        check(out_data, expq.pop_front());
    end
  end

  // ----
  // sequence
  // ----
  initial
  begin
    void'($urandom(32'he80f));
    repeat (8) @(posedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    check(result, 64'h0);
    check(out_valid, 64'h0);
    for (c = 0; c < 4; c++)
    begin
      @(posedge clk);
      {pipe_reg_en, in_reg_en} <= c[1:0];
      @(posedge clk);
      send(18'h2, 18'h3ffff, c[0], 52'h5);
      in_valid <= 1'h0;
      k = 0;
      do
      begin
        @(negedge clk);
        k++;
      end
      while (!out_valid && k < 9);
      check(k, 2 + c[0] + c[1]);
    end
    @(posedge clk);
    send(18'h1, 18'h1, 1'h1, 52'h7ffffffffffff);
    send(18'h3ffff, 18'h1, 1'h1, 52'h8000000000000);
    send(18'h0, 18'h0, 1'h0, 52'h0);
    hold <= 1'h1;
    slow <= 1'h1;
    fork
      begin
        repeat (12) @(posedge clk);
        hold <= 1'h0;
      end
    join_none
    for (k = 0; k < 60; k++)
      send(18'($urandom), 18'($urandom), $urandom_range(7) == 0, 52'({$urandom, $urandom}));
    in_valid <= 1'h0;
    slow <= 1'h0;
    k = 0;
    while (expq.size() && k < 999)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 999)
      give_up;
    @(negedge clk);
    check(result, 52'(acc));
    check(overflow, ov);
    test_done;
  end
endmodule : test_multiply_accumulate_unit
`default_nettype wire
